/* File: dv/acc_plant.sv */
// Purpose: operator, sensor and interlock side facing the engage controller
// Assumes: inputs change on falling clock edges only
// Notes: buttons are debounced levels, so a press is one clean high stretch
`timescale 1ns/1ns
module acc_plant (
  // clock
  input wire logic clk,
  // toward the controller
  output logic power_btn,
  output logic mode_btn,
  output logic interlock,
  output acc_pkg::acc_sense_t sense
);
  initial begin
    power_btn = 1'b0;
    mode_btn = 1'b0;
    interlock = 1'b0;
    sense = '0;
  end

  // ****************************************
  // operator and plant actions
  // ****************************************
  // press one or both buttons for n rising edges, then leave two idle edges
  task automatic hold(input logic pw, input logic md, input int n);
    @(negedge clk);
    power_btn = pw;
    mode_btn = md;
    repeat (n) @(negedge clk);
    power_btn = 1'b0;
    mode_btn = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  // flags: speed_ok, pressure_ok, temp_ok, low_foam, trans_hot
  task automatic set(input logic [13:0] spd, input logic [13:0] prs, input logic [13:0] tmp,
                     input logic [4:0] flg, input logic ilk);
    @(negedge clk);
    sense = {spd, prs, tmp, flg};
    interlock = ilk;
  endtask
endmodule

/* File: dv/testbench.sv */
// Purpose: self-checking bench for the compressor engage controller
// Assumes: shortened hold, idle and flash counts
// Notes: each case restores healthy sensors before it engages again
`timescale 1ns/1ns
module testbench;
  logic clk;
  logic reset_n;
  logic power_btn;
  logic mode_btn;
  logic interlock;
  acc_pkg::acc_sense_t sense;
  logic clutch_drive;
  logic engaged_led;
  acc_pkg::acc_disp_t disp;
  int mismatches;
  int num_checks;
  logic alt;
  logic [13:0] spd [8] = '{14'd1550, 14'd1850, 14'd1851, 14'd100, 14'd100, 14'd100, 14'd100,
                           14'd100};
  logic [13:0] tmp [8] = '{14'd70, 14'd70, 14'd70, 14'd213, 14'd240, 14'd241, 14'd70, 14'd70};
  logic [4:0] flg [8] = '{5'h1c, 5'h1c, 5'h1c, 5'h1c, 5'h1c, 5'h1c, 5'h1e, 5'h1d};
  logic [15:0] msg [8] = '{16'h1, 16'h1, 16'h2, 16'h3, 16'h3, 16'h4, 16'h6, 16'h5};
  logic on [8] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
  logic [4:0] bad [3] = '{5'h0c, 5'h14, 5'h18};
  logic [15:0] code [3] = '{16'h3, 16'h5, 16'ha};

  acc_engage_ctrl #(.HOLD_ON_CYC(20), .HOLD_PROG_CYC(30), .IDLE_TIMEOUT_CYC(40),
                    .FLASH_CYC(8)) i_acc_engage_ctrl (.clk(clk), .reset_n(reset_n),
    .power_btn(power_btn), .mode_btn(mode_btn), .interlock(interlock), .sense(sense),
    .clutch_drive(clutch_drive), .engaged_led(engaged_led), .disp(disp));
  acc_plant i_acc_plant (.clk(clk), .power_btn(power_btn), .mode_btn(mode_btn),
    .interlock(interlock), .sense(sense));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ****************************************
  // compare and verdict
  // ****************************************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    if (mismatches == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // generous bound, the whole sequence needs about 850 cycles
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    summarize();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    reset_n = 1'b0;
    mismatches = 0;
    num_checks = 0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    check("clutch", {15'h0, clutch_drive}, 16'h0);
    check("view", {14'h0, disp.view}, 16'h0);
    i_acc_plant.set(14'd100, 14'd9, 14'd70, 5'h1c, 1'b0);
    i_acc_plant.hold(1'b1, 1'b0, 22);
    check("clutch", {15'h0, clutch_drive}, 16'h0);
    i_acc_plant.set(14'd100, 14'd10, 14'd70, 5'h1c, 1'b1);
    i_acc_plant.hold(1'b1, 1'b0, 22);
    check("clutch", {15'h0, clutch_drive}, 16'h0);
    i_acc_plant.set(14'd100, 14'd9, 14'd211, 5'h1c, 1'b1);
    i_acc_plant.hold(1'b1, 1'b0, 22);
    check("clutch", {15'h0, clutch_drive}, 16'h1);
    check("led", {15'h0, engaged_led}, 16'h1);
    i_acc_plant.hold(1'b1, 1'b0, 22);
    check("clutch", {15'h0, clutch_drive}, 16'h0);
    for (int i = 0; i < 8; i++) begin
      i_acc_plant.set(14'd100, 14'd9, 14'd70, 5'h1c, 1'b1);
      i_acc_plant.hold(1'b1, 1'b0, 22);
      i_acc_plant.set(spd[i], 14'd9, tmp[i], flg[i], 1'b1);
      repeat (2) @(negedge clk);
      check("msg", {13'h0, disp.msg}, msg[i]);
      check("clutch", {15'h0, clutch_drive}, {15'h0, on[i]});
      if (on[i]) begin
        i_acc_plant.hold(1'b1, 1'b0, 22);
      end
    end
    for (int i = 0; i < 3; i++) begin
      i_acc_plant.set(14'd100, 14'd9, 14'd70, bad[i], 1'b0);
      repeat (2) @(negedge clk);
      check("fault", {12'h0, disp.fault}, code[i]);
    end
    i_acc_plant.set(14'd100, 14'd9, 14'd70, 5'h1c, 1'b0);
    for (int i = 1; i < 4; i++) begin
      i_acc_plant.hold(1'b0, 1'b1, 1);
      check("view", {14'h0, disp.view}, 16'(i % 3));
    end
    // enter code 315, then edit its leftmost digit
    i_acc_plant.hold(1'b0, 1'b1, 32);
    check("prog", {13'h0, disp.prog}, 16'h1);
    i_acc_plant.hold(1'b1, 1'b0, 1);
    check("digits", disp.digits, 16'h0100);
    repeat (2) i_acc_plant.hold(1'b1, 1'b0, 1);
    check("digits", disp.digits, 16'h0300);
    i_acc_plant.hold(1'b0, 1'b1, 1);
    check("sel", {14'h0, disp.sel}, 16'h1);
    i_acc_plant.hold(1'b0, 1'b1, 1);
    check("digits", disp.digits, 16'h0310);
    i_acc_plant.hold(1'b1, 1'b0, 1);
    check("prog", {13'h0, disp.prog}, 16'h4);
    repeat (5) i_acc_plant.hold(1'b1, 1'b0, 1);
    i_acc_plant.hold(1'b0, 1'b1, 1);
    check("prog", {13'h0, disp.prog}, 16'h5);
    check("digits", disp.digits, 16'h1850);
    i_acc_plant.hold(1'b0, 1'b1, 1);
    i_acc_plant.hold(1'b1, 1'b0, 1);
    check("digits", disp.digits, 16'h2850);
    repeat (50) @(negedge clk);
    check("prog", {13'h0, disp.prog}, 16'h5);
    i_acc_plant.hold(1'b1, 1'b1, 32);
    check("prog", {13'h0, disp.prog}, 16'h0);
    // code 100 is not a setting
    i_acc_plant.hold(1'b0, 1'b1, 32);
    i_acc_plant.hold(1'b1, 1'b0, 1);
    i_acc_plant.hold(1'b0, 1'b1, 1);
    i_acc_plant.hold(1'b1, 1'b0, 1);
    i_acc_plant.hold(1'b0, 1'b1, 1);
    check("prog", {13'h0, disp.prog}, 16'h6);
    repeat (45) @(negedge clk);
    check("prog", {13'h0, disp.prog}, 16'h0);
    // program code 321 to on, then let the interlock start the compressor
    i_acc_plant.hold(1'b0, 1'b1, 32);
    repeat (3) i_acc_plant.hold(1'b1, 1'b0, 1);
    repeat (3) i_acc_plant.hold(1'b0, 1'b1, 1);
    repeat (2) i_acc_plant.hold(1'b1, 1'b0, 1);
    i_acc_plant.hold(1'b0, 1'b1, 1);
    check("prog", {13'h0, disp.prog}, 16'h5);
    check("digits", disp.digits, 16'h0000);
    // the power edge of the exit hold steps the option once, to on
    i_acc_plant.hold(1'b1, 1'b1, 32);
    check("prog", {13'h0, disp.prog}, 16'h0);
    i_acc_plant.set(14'd100, 14'd9, 14'd70, 5'h1c, 1'b1);
    repeat (2) @(negedge clk);
    check("clutch", {15'h0, clutch_drive}, 16'h1);
    alt = disp.alt_value;
    repeat (8) @(negedge clk);
    check("alt", {15'h0, disp.alt_value}, {15'h0, ~alt});
    summarize();
  end
endmodule

/* File: logic/acc_button.sv */
// Purpose: press edge, short release and hold detection for one button level
// Assumes: level is synchronous and already debounced
// Notes: hold fires once per press, after HOLD_CYC cycles of continuous level
`timescale 1ns/1ns
module acc_button #(
  parameter int unsigned HOLD_CYC = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // button
  input wire logic level,
  // events
  output logic press,
  output logic short_rel,
  output logic hold
);
  localparam int W = $clog2(HOLD_CYC + 1);

  logic prev;
  logic [W-1:0] cnt;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prev <= 1'b0;
    end else begin
      prev <= level;
    end
  end

  // saturates so a long hold cannot fire twice
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= '0;
    end else if (!level) begin
      cnt <= '0;
    end else if (cnt != W'(HOLD_CYC)) begin
      cnt <= cnt + 1'b1;
    end
  end

  assign press = level & ~prev;
  assign hold = level && (cnt == W'(HOLD_CYC - 1));
  assign short_rel = prev & ~level & (cnt != W'(HOLD_CYC));
endmodule

/* File: logic/acc_engage_ctrl.sv */
// Purpose: compressor clutch supervisor with warnings and parameter programming
// Assumes: buttons and sensor flags are synchronous to clk
// Notes: settings live in a small BCD array, editable through two buttons
// Operation
// RL1 - power button ignored unless interlock is asserted
// RL2 - two second power hold toggles engagement on or off
// RL3 - mode press cycles speed, airflow, hours views; speed is default
// RL4 - with interlock, auto engage once start permits are met
// RL5 - engage only with pressure below 10 psi, oil below 212 F
// RL6 - engaged indicator only while clutch driven and conditions met
// RL7 - disengage when speed exceeds code 315 setting
// RL8 - disengage above 240 F, flash shutdown with compressor hot
// RL9 - low foam or transmission hot disengages and flashes cause
// RL10 - distinct fault codes for missing speed, pressure, temperature sensors
// RL11 - speed within 314..315 settings flashes high speed warning
// RL12 - speed above 315 setting flashes overspeed message
// RL13 - oil between warning and shutdown temps flashes compressor hot
// RL14 - oil above shutdown temperature flashes shutdown with compressor hot
// RL15 - mode hold 3 s enters entry; both held 3 s exits
// RL16 - three seconds idle leaves programming, except while value shown
// RL17 - power press at dashes shows 100, power increments first digit
// RL18 - mode moves to and increments second digit, power third
// RL19 - valid code shows stored value, invalid shows error
// RL20 - when shown, mode selects next digit, power changes it
// RL21 - speed defaults 313=900, 314=1550, 315=1850
// RL22 - units 310, 311, temps 316=212, 317=240, auto start 321
`timescale 1ns/1ns
module acc_engage_ctrl #(
  parameter int unsigned HOLD_ON_CYC = acc_pkg::HOLD_ON_CYC,
  parameter int unsigned HOLD_PROG_CYC = acc_pkg::HOLD_PROG_CYC,
  parameter int unsigned IDLE_TIMEOUT_CYC = acc_pkg::IDLE_TIMEOUT_CYC,
  parameter int unsigned FLASH_CYC = acc_pkg::FLASH_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // operator buttons
  input wire logic power_btn,
  input wire logic mode_btn,
  // plant
  input wire logic interlock,
  input wire acc_pkg::acc_sense_t sense,
  output logic clutch_drive,
  output logic engaged_led,
  // display
  output acc_pkg::acc_disp_t disp
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [13:0] bcd2bin(input logic [15:0] b);
    bcd2bin = {10'h000, b[15:12]} * 14'h03e8 + {10'h000, b[11:8]} * 14'h0064
            + {10'h000, b[7:4]} * 14'h000a + {10'h000, b[3:0]};
  endfunction

  function automatic logic [15:0] dig_inc(input logic [15:0] v, input logic [1:0] sel);
    logic [3:0] d;
    d = v[sel*4 +: 4];
    dig_inc = v;
    dig_inc[sel*4 +: 4] = (d == 4'h9) ? 4'h0 : d + 4'h1;
  endfunction

  // returns {valid, slot}
  function automatic logic [3:0] code_slot(input logic [11:0] c);
    case (c)
      acc_pkg::CODE_PRESS_UNITS: code_slot = {1'b1, acc_pkg::SLOT_PRESS_UNITS};
      acc_pkg::CODE_TEMP_UNITS: code_slot = {1'b1, acc_pkg::SLOT_TEMP_UNITS};
      acc_pkg::CODE_MAX_ENGAGE: code_slot = {1'b1, acc_pkg::SLOT_MAX_ENGAGE};
      acc_pkg::CODE_WARN_SPEED: code_slot = {1'b1, acc_pkg::SLOT_WARN_SPEED};
      acc_pkg::CODE_TRIP_SPEED: code_slot = {1'b1, acc_pkg::SLOT_TRIP_SPEED};
      acc_pkg::CODE_WARN_TEMP: code_slot = {1'b1, acc_pkg::SLOT_WARN_TEMP};
      acc_pkg::CODE_TRIP_TEMP: code_slot = {1'b1, acc_pkg::SLOT_TRIP_TEMP};
      acc_pkg::CODE_AUTO_ON: code_slot = {1'b1, acc_pkg::SLOT_AUTO_ON};
      default: code_slot = 4'h0;
    endcase
  endfunction

  function automatic logic [15:0] slot_default(input logic [2:0] s);
    case (s)
      acc_pkg::SLOT_MAX_ENGAGE: slot_default = acc_pkg::DEF_MAX_ENGAGE;
      acc_pkg::SLOT_WARN_SPEED: slot_default = acc_pkg::DEF_WARN_SPEED;
      acc_pkg::SLOT_TRIP_SPEED: slot_default = acc_pkg::DEF_TRIP_SPEED;
      acc_pkg::SLOT_WARN_TEMP: slot_default = acc_pkg::DEF_WARN_TEMP;
      acc_pkg::SLOT_TRIP_TEMP: slot_default = acc_pkg::DEF_TRIP_TEMP;
      default: slot_default = acc_pkg::DEF_OPTION;
    endcase
  endfunction

  // number of choices for option slots, zero for numeric ones
  function automatic logic [3:0] slot_choices(input logic [2:0] s);
    case (s)
      acc_pkg::SLOT_PRESS_UNITS: slot_choices = acc_pkg::UNITS_CHOICES;
      acc_pkg::SLOT_TEMP_UNITS, acc_pkg::SLOT_AUTO_ON: slot_choices = acc_pkg::BINARY_CHOICES;
      default: slot_choices = 4'h0;
    endcase
  endfunction

  // ****************************************
  // buttons
  // ****************************************
  logic p_press, p_hold, m_press, m_short, m_hold, both_hold;

  acc_button #(.HOLD_CYC(HOLD_ON_CYC)) u_power (
    .clk(clk), .reset_n(reset_n), .level(power_btn),
    .press(p_press), .short_rel(), .hold(p_hold)
  );
  acc_button #(.HOLD_CYC(HOLD_PROG_CYC)) u_mode (
    .clk(clk), .reset_n(reset_n), .level(mode_btn),
    .press(m_press), .short_rel(m_short), .hold(m_hold)
  );
  acc_button #(.HOLD_CYC(HOLD_PROG_CYC)) u_both (
    .clk(clk), .reset_n(reset_n), .level(power_btn & mode_btn),
    .press(), .short_rel(), .hold(both_hold)
  );

  // ****************************************
  // settings
  // ****************************************
  logic [15:0] params [0:7];
  acc_pkg::acc_prog_t prog;
  logic [15:0] digits;
  logic [1:0] sel;
  logic [2:0] slot;
  logic [3:0] hit;
  logic [3:0] choices;
  logic [3:0] next_opt;

  assign choices = slot_choices(slot);
  assign next_opt = (params[slot][3:0] + 4'h1 >= choices) ? 4'h0 : params[slot][3:0] + 4'h1;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 8; i++) begin
        params[i] <= slot_default(3'(i)); // [RL21] [RL22]
      end
    end else if (prog == acc_pkg::PROG_SHOW && p_press && !both_hold) begin
      if (choices != 4'h0) begin
        params[slot] <= {12'h000, next_opt}; // [RL20]
      end else begin
        params[slot] <= dig_inc(params[slot], sel); // [RL20]
      end
    end
  end

  logic [13:0] max_eng, warn_spd, trip_spd, warn_tmp, trip_tmp;
  logic auto_on;
  assign max_eng = bcd2bin(params[acc_pkg::SLOT_MAX_ENGAGE]);
  assign warn_spd = bcd2bin(params[acc_pkg::SLOT_WARN_SPEED]);
  assign trip_spd = bcd2bin(params[acc_pkg::SLOT_TRIP_SPEED]);
  assign warn_tmp = bcd2bin(params[acc_pkg::SLOT_WARN_TEMP]);
  assign trip_tmp = bcd2bin(params[acc_pkg::SLOT_TRIP_TEMP]);
  assign auto_on = params[acc_pkg::SLOT_AUTO_ON][0];

  // ****************************************
  // programming sequence
  // ****************************************
  localparam int TW = $clog2(IDLE_TIMEOUT_CYC + 1);
  logic [TW-1:0] idle_cnt;
  logic timed, timeout;

  // a shown value waits for the operator indefinitely
  assign timed = prog != acc_pkg::PROG_OFF && prog != acc_pkg::PROG_SHOW; // [RL16]
  assign timeout = timed && idle_cnt == TW'(IDLE_TIMEOUT_CYC - 1);
  assign hit = code_slot(digits[11:0]);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      idle_cnt <= '0;
    end else if (!timed || power_btn || mode_btn) begin
      idle_cnt <= '0;
    end else begin
      idle_cnt <= idle_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prog <= acc_pkg::PROG_OFF;
      digits <= '0;
      sel <= '0;
      slot <= '0;
    end else if (prog != acc_pkg::PROG_OFF && (both_hold || timeout)) begin
      prog <= acc_pkg::PROG_OFF; // [RL15] [RL16]
    end else begin
      case (prog)
        acc_pkg::PROG_OFF: begin
          if (m_hold) prog <= acc_pkg::PROG_DASHES; // [RL15]
        end
        acc_pkg::PROG_DASHES: begin
          if (p_press) begin
            prog <= acc_pkg::PROG_DIG1; // [RL17]
            digits <= acc_pkg::ENTRY_START;
            sel <= 2'h2;
          end
        end
        acc_pkg::PROG_DIG1: begin
          if (p_press) begin
            digits <= dig_inc(digits, sel); // [RL17]
          end else if (m_press) begin
            prog <= acc_pkg::PROG_DIG2; // [RL18]
            sel <= 2'h1;
          end
        end
        acc_pkg::PROG_DIG2: begin
          if (m_press) begin
            digits <= dig_inc(digits, sel); // [RL18]
          end else if (p_press) begin
            prog <= acc_pkg::PROG_DIG3; // [RL18]
            sel <= 2'h0;
          end
        end
        acc_pkg::PROG_DIG3: begin
          if (p_press) begin
            digits <= dig_inc(digits, sel); // [RL18]
          end else if (m_press) begin
            // mode after the third digit commits the code
            prog <= hit[3] ? acc_pkg::PROG_SHOW : acc_pkg::PROG_ERROR; // [RL19]
            slot <= hit[2:0];
            sel <= 2'h0;
          end
        end
        acc_pkg::PROG_SHOW: begin
          if (m_press) sel <= sel - 2'h1; // [RL20]
        end
        default: ;
      endcase
    end
  end

  // ****************************************
  // engagement
  // ****************************************
  logic permit, speed_over, temp_trip, trip, auto_armed, next_engaged;

  assign permit = sense.pressure_ok && sense.temp_ok && sense.speed_ok
                  && sense.pressure < acc_pkg::PERMIT_PRESS_PSI
                  && sense.temp < acc_pkg::PERMIT_TEMP_F
                  && sense.speed <= max_eng; // [RL5]
  assign speed_over = sense.speed_ok && sense.speed > trip_spd;
  assign temp_trip = sense.temp_ok && sense.temp > trip_tmp;
  assign trip = speed_over || temp_trip || sense.low_foam || sense.trans_hot || !interlock;

  always_comb begin
    next_engaged = clutch_drive;
    if (trip) begin
      next_engaged = 1'b0; // [RL7] [RL8] [RL9]
    end else if (p_hold && interlock && prog == acc_pkg::PROG_OFF) begin
      next_engaged = !clutch_drive && permit; // [RL1] [RL2] [RL5]
    end else if (interlock && auto_on && auto_armed && permit) begin
      next_engaged = 1'b1; // [RL4]
    end
  end

  // auto start fires once per interlock assertion so a manual stop sticks
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      auto_armed <= 1'b1;
    end else if (!interlock) begin
      auto_armed <= 1'b1;
    end else if (next_engaged && !clutch_drive) begin
      auto_armed <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clutch_drive <= 1'b0;
      engaged_led <= 1'b0;
    end else begin
      clutch_drive <= next_engaged;
      engaged_led <= next_engaged && !trip; // [RL6]
    end
  end

  // ****************************************
  // display
  // ****************************************
  localparam int FW = $clog2(FLASH_CYC + 1);
  logic [FW-1:0] flash_cnt;
  logic flash_phase;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flash_cnt <= '0;
      flash_phase <= 1'b0;
    end else if (flash_cnt == FW'(FLASH_CYC - 1)) begin
      flash_cnt <= '0;
      flash_phase <= ~flash_phase;
    end else begin
      flash_cnt <= flash_cnt + 1'b1;
    end
  end

  // one writer for the whole display word, fields may not be split across processes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      disp.view <= acc_pkg::VIEW_SPEED; // [RL3]
      disp.msg <= acc_pkg::MSG_NONE;
      disp.fault <= acc_pkg::FAULT_NONE;
      disp.alt_value <= 1'b0;
      disp.prog <= acc_pkg::PROG_OFF;
      disp.digits <= '0;
      disp.sel <= '0;
    end else begin
      if (prog == acc_pkg::PROG_OFF && m_short) begin
        case (disp.view)
          acc_pkg::VIEW_SPEED: disp.view <= acc_pkg::VIEW_AIRFLOW; // [RL3]
          acc_pkg::VIEW_AIRFLOW: disp.view <= acc_pkg::VIEW_HOURS;
          default: disp.view <= acc_pkg::VIEW_SPEED;
        endcase
      end
      if (temp_trip) disp.msg <= acc_pkg::MSG_SHUT_COMPRESSOR_HOT_TEXT; // [RL8] [RL14]
      else if (sense.trans_hot) disp.msg <= acc_pkg::MSG_SHUT_TRANS_HOT; // [RL9]
      else if (sense.low_foam) disp.msg <= acc_pkg::MSG_SHUT_LOW_FOAM; // [RL9]
      else if (speed_over) disp.msg <= acc_pkg::MSG_OVERSPEED; // [RL12]
      else if (sense.speed_ok && sense.speed >= warn_spd) begin
        disp.msg <= acc_pkg::MSG_HIGH_SPEED; // [RL11]
      end else if (sense.temp_ok && sense.temp > warn_tmp) begin
        disp.msg <= acc_pkg::MSG_COMPRESSOR_HOT_TEXT; // [RL13]
      end else disp.msg <= acc_pkg::MSG_NONE;
      if (!sense.speed_ok) disp.fault <= acc_pkg::FAULT_NO_SPEED; // [RL10]
      else if (!sense.pressure_ok) disp.fault <= acc_pkg::FAULT_NO_PRESSURE_SENSOR; // [RL10]
      else if (!sense.temp_ok) disp.fault <= acc_pkg::FAULT_NO_TEMP_SENSOR; // [RL10]
      else disp.fault <= acc_pkg::FAULT_NONE;
      disp.alt_value <= flash_phase;
      disp.prog <= prog;
      disp.digits <= (prog == acc_pkg::PROG_SHOW) ? params[slot] : digits; // [RL19]
      disp.sel <= sel;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_dashes_press;
    prog == acc_pkg::PROG_DASHES && p_press && !both_hold && !timeout;
  endsequence
  sequence s_commit;
    prog == acc_pkg::PROG_DIG3 && m_press && !p_press && !both_hold && !timeout;
  endsequence

  AST_NO_INTERLOCK: assert property (!interlock |=> !clutch_drive) // [RL1]
    else $error("engaged without interlock");
  AST_HOLD_OFF: assert property (clutch_drive && p_hold // [RL2]
    && prog == acc_pkg::PROG_OFF |=> !clutch_drive)
    else $error("hold did not disengage");
  AST_VIEW_WRAP: assert property (prog == acc_pkg::PROG_OFF && m_short // [RL3]
    && disp.view == acc_pkg::VIEW_HOURS |=> disp.view == acc_pkg::VIEW_SPEED)
    else $error("view did not wrap");
  AST_AUTO: assert property (!trip && auto_on && auto_armed && permit && !p_hold // [RL4]
    |=> clutch_drive)
    else $error("auto engage missed");
  AST_PERMIT: assert property ($rose(clutch_drive) |-> $past(permit)) // [RL5]
    else $error("engaged without permit");
  AST_LED: assert property (engaged_led |-> clutch_drive) // [RL6]
    else $error("indicator without clutch");
  AST_OVERSPEED: assert property (speed_over |=> !clutch_drive // [RL7]
    && (disp.msg == acc_pkg::MSG_OVERSPEED || disp.msg >= acc_pkg::MSG_SHUT_COMPRESSOR_HOT_TEXT))
    else $error("overspeed not handled");
  AST_HOT: assert property (temp_trip |=> !clutch_drive // [RL8]
    && disp.msg == acc_pkg::MSG_SHUT_COMPRESSOR_HOT_TEXT)
    else $error("oil trip not handled");
  AST_CAUSE: assert property (sense.low_foam && !temp_trip && !sense.trans_hot // [RL9]
    |=> !clutch_drive && disp.msg == acc_pkg::MSG_SHUT_LOW_FOAM)
    else $error("low foam not handled");
  AST_NO_SPEED: assert property (!sense.speed_ok // [RL10]
    |=> disp.fault == acc_pkg::FAULT_NO_SPEED)
    else $error("missing speed fault");
  AST_ENTER: assert property (prog == acc_pkg::PROG_OFF && m_hold // [RL15]
    |=> prog == acc_pkg::PROG_DASHES ##1 disp.prog == acc_pkg::PROG_DASHES)
    else $error("entry hold ignored");
  AST_SHOW_STAYS: assert property (prog == acc_pkg::PROG_SHOW && !both_hold // [RL16]
    |=> prog == acc_pkg::PROG_SHOW)
    else $error("shown value timed out");
  AST_START_100: assert property (s_dashes_press // [RL17]
    |=> prog == acc_pkg::PROG_DIG1 && digits == acc_pkg::ENTRY_START)
    else $error("entry did not start at 100");
  AST_COMMIT: assert property (s_commit |=> prog == acc_pkg::PROG_SHOW // [RL19]
    || prog == acc_pkg::PROG_ERROR)
    else $error("code not evaluated");
endmodule

/* File: logic/acc_pkg.sv */
// Purpose: shared constants and types of the air compressor engage controller
// Assumes: 25 MHz system clock, sensor values already scaled to psi, F and rpm
// Notes: stored settings are four BCD digits so they can be edited digit by digit
package acc_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_KHZ = 25000;
  localparam int unsigned HOLD_ON_MS = 2000;
  localparam int unsigned HOLD_PROG_MS = 3000;
  localparam int unsigned IDLE_TIMEOUT_MS = 3000;
  localparam int unsigned FLASH_MS = 500;
  localparam int unsigned HOLD_ON_CYC = HOLD_ON_MS * CLK_KHZ;
  localparam int unsigned HOLD_PROG_CYC = HOLD_PROG_MS * CLK_KHZ;
  localparam int unsigned IDLE_TIMEOUT_CYC = IDLE_TIMEOUT_MS * CLK_KHZ;
  localparam int unsigned FLASH_CYC = FLASH_MS * CLK_KHZ;

  // ****************************************
  // fixed limits and settings
  // ****************************************
  localparam logic [13:0] PERMIT_PRESS_PSI = 14'h000a;
  localparam logic [13:0] PERMIT_TEMP_F = 14'h00d4;
  localparam logic [15:0] ENTRY_START = 16'h0100;
  localparam logic [2:0] SLOT_PRESS_UNITS = 3'h0;
  localparam logic [2:0] SLOT_TEMP_UNITS = 3'h1;
  localparam logic [2:0] SLOT_MAX_ENGAGE = 3'h2;
  localparam logic [2:0] SLOT_WARN_SPEED = 3'h3;
  localparam logic [2:0] SLOT_TRIP_SPEED = 3'h4;
  localparam logic [2:0] SLOT_WARN_TEMP = 3'h5;
  localparam logic [2:0] SLOT_TRIP_TEMP = 3'h6;
  localparam logic [2:0] SLOT_AUTO_ON = 3'h7;
  localparam logic [11:0] CODE_PRESS_UNITS = 12'h310;
  localparam logic [11:0] CODE_TEMP_UNITS = 12'h311;
  localparam logic [11:0] CODE_MAX_ENGAGE = 12'h313;
  localparam logic [11:0] CODE_WARN_SPEED = 12'h314;
  localparam logic [11:0] CODE_TRIP_SPEED = 12'h315;
  localparam logic [11:0] CODE_WARN_TEMP = 12'h316;
  localparam logic [11:0] CODE_TRIP_TEMP = 12'h317;
  localparam logic [11:0] CODE_AUTO_ON = 12'h321;
  localparam logic [15:0] DEF_OPTION = 16'h0000;
  localparam logic [15:0] DEF_MAX_ENGAGE = 16'h0900;
  localparam logic [15:0] DEF_WARN_SPEED = 16'h1550;
  localparam logic [15:0] DEF_TRIP_SPEED = 16'h1850;
  localparam logic [15:0] DEF_WARN_TEMP = 16'h0212;
  localparam logic [15:0] DEF_TRIP_TEMP = 16'h0240;
  localparam logic [3:0] UNITS_CHOICES = 4'h3;
  localparam logic [3:0] BINARY_CHOICES = 4'h2;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    VIEW_SPEED = 2'h0, VIEW_AIRFLOW = 2'h1, VIEW_HOURS = 2'h2
  } acc_view_t;

  typedef enum logic [2:0] {
    MSG_NONE = 3'h0, MSG_HIGH_SPEED = 3'h1, MSG_OVERSPEED = 3'h2,
    MSG_COMPRESSOR_HOT_TEXT = 3'h3, MSG_SHUT_COMPRESSOR_HOT_TEXT = 3'h4, MSG_SHUT_TRANS_HOT = 3'h5,
    MSG_SHUT_LOW_FOAM = 3'h6
  } acc_msg_t;

  typedef enum logic [3:0] {
    FAULT_NONE = 4'h0, FAULT_NO_SPEED = 4'h3, FAULT_NO_PRESSURE_SENSOR = 4'h5,
    FAULT_NO_TEMP_SENSOR = 4'ha
  } acc_fault_t;

  typedef enum logic [2:0] {
    PROG_OFF = 3'h0, PROG_DASHES = 3'h1, PROG_DIG1 = 3'h2, PROG_DIG2 = 3'h3,
    PROG_DIG3 = 3'h4, PROG_SHOW = 3'h5, PROG_ERROR = 3'h6
  } acc_prog_t;

  typedef struct packed {
    logic [13:0] speed;
    logic [13:0] pressure;
    logic [13:0] temp;
    logic speed_ok;
    logic pressure_ok;
    logic temp_ok;
    logic low_foam;
    logic trans_hot;
  } acc_sense_t;

  typedef struct packed {
    acc_view_t view;
    acc_msg_t msg;
    logic alt_value;
    acc_fault_t fault;
    acc_prog_t prog;
    logic [15:0] digits;
    logic [1:0] sel;
  } acc_disp_t;

endpackage
